// file: common/cap_word_if.sv
/*
 * Carrier between the register front end and the capability word encoder.
 * Assumes the front end owns the port role and the encoder is purely combinational.
 */
`timescale 1ns/1ns
`default_nettype none

interface cap_word_if;
    logic        upstreamPort;
    logic [31:0] firstWord;
    logic [31:0] secondWord;

    modport encoder
    (
        input  upstreamPort,
        output firstWord,
        output secondWord
    );

    modport reader
    (
        output upstreamPort,
        input  firstWord,
        input  secondWord
    );
endinterface

`default_nettype wire

// file: common/vc_cap_pkg.sv
/*
 * Constants for the port virtual channel capability registers:
 * offsets, field positions, fixed field values and entry size codes.
 * Assumes 12-bit configuration byte addresses and 32-bit data.
 */
package vc_cap_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register byte offsets inside the configuration space
    localparam logic [11:0] OFFSET_CAP_FIRST  = 12'h204;
    localparam logic [11:0] OFFSET_CAP_SECOND = 12'h208;

    // first capability word fields
    localparam int EXTRA_COUNT_LSB    = 0;
    localparam int EXTRA_COUNT_W      = 3;
    localparam int LOW_PRI_COUNT_LSB  = 4;
    localparam int LOW_PRI_COUNT_W    = 3;
    localparam int TIME_BASE_LSB      = 8;
    localparam int TIME_BASE_W        = 2;
    localparam int ENTRY_SIZE_LSB     = 10;
    localparam int ENTRY_SIZE_W       = 2;

    // second capability word fields
    localparam int ARB_SCHEMES_LSB    = 0;
    localparam int ARB_SCHEMES_W      = 8;
    localparam int TABLE_OFFSET_LSB   = 24;
    localparam int TABLE_OFFSET_W     = 8;
    localparam int TABLE_OFFSET_UNIT  = 16;

    // fixed field values
    localparam logic [2:0] EXTRA_COUNT_VALUE   = 3'h0;
    localparam logic [2:0] LOW_PRI_COUNT_VALUE = 3'h0;
    localparam logic [1:0] TIME_BASE_VALUE     = 2'h0;
    localparam logic [7:0] ARB_SCHEMES_VALUE   = 8'h00;
    localparam logic [7:0] TABLE_OFFSET_VALUE  = 8'h00;
    localparam logic [31:0] RESET_WORD         = 32'h0000_0000;

    // channel arbitration scheme bit positions
    localparam int ARB_BIT_FIXED_RR = 0;
    localparam int ARB_BIT_WRR32    = 1;
    localparam int ARB_BIT_WRR64    = 2;
    localparam int ARB_BIT_WRR128   = 3;

    // port arbitration table entry size encoding
    typedef enum logic [1:0]
    {
        ENTRY_ONE_BIT   = 2'h0,
        ENTRY_TWO_BIT   = 2'h1,
        ENTRY_FOUR_BIT  = 2'h2,
        ENTRY_EIGHT_BIT = 2'h3
    } entry_size_type;

    localparam entry_size_type ENTRY_SIZE_UPSTREAM   = ENTRY_FOUR_BIT;
    localparam entry_size_type ENTRY_SIZE_DOWNSTREAM = ENTRY_ONE_BIT;

endpackage

// file: logic/cap_word_encoder.sv
/*
 * Builds the two fixed capability words from the port role.
 * Assumes the role input is stable while words are sampled.
 */
`timescale 1ns/1ns
`default_nettype none

module cap_word_encoder
    import vc_cap_pkg::*;
(
    cap_word_if.encoder words
);

    function automatic logic [1:0] entry_code(input logic upstream);
        entry_code = upstream ? ENTRY_SIZE_UPSTREAM : ENTRY_SIZE_DOWNSTREAM;
    endfunction

    always_comb
    begin
        // reserved bits stay zero
        words.firstWord = RESET_WORD;
        words.firstWord[EXTRA_COUNT_LSB +: EXTRA_COUNT_W]     = EXTRA_COUNT_VALUE;
        words.firstWord[LOW_PRI_COUNT_LSB +: LOW_PRI_COUNT_W] = LOW_PRI_COUNT_VALUE;
        words.firstWord[TIME_BASE_LSB +: TIME_BASE_W]         = TIME_BASE_VALUE;
        words.firstWord[ENTRY_SIZE_LSB +: ENTRY_SIZE_W]       = entry_code(words.upstreamPort);
        words.secondWord = RESET_WORD;
        words.secondWord[ARB_SCHEMES_LSB +: ARB_SCHEMES_W]   = ARB_SCHEMES_VALUE;
        words.secondWord[TABLE_OFFSET_LSB +: TABLE_OFFSET_W] = TABLE_OFFSET_VALUE;
    end

endmodule

`default_nettype wire

// file: logic/port_vc_capability_regs.sv
/*
 * Port virtual channel capability registers on the configuration access port.
 * Assumes single-cycle read and write strobes with a dword byte address,
 * and a port role strap that is steady around reset release.
 */
`timescale 1ns/1ns
`default_nettype none

module port_vc_capability_regs
    import vc_cap_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      upstreamStrap,
    input  wire logic                      cfgRead,
    input  wire logic                      cfgWrite,
    input  wire logic [vc_cap_pkg::ADDR_W-1:0] cfgAddr,
    input  wire logic [vc_cap_pkg::DATA_W-1:0] cfgWriteData,
    input  wire logic [3:0]                cfgByteEnable,
    output logic [vc_cap_pkg::DATA_W-1:0]  cfgReadData,
    output logic                           cfgDone,
    output logic                           cfgHit,
    output logic                           upstreamRole
);
    import vc_cap_pkg::*;

    typedef enum logic
    {
        ROLE_PENDING,
        ROLE_HELD
    } role_state_type;

    role_state_type roleState;
    role_state_type next_roleState;
    logic           next_upstreamRole;
    logic [31:0]    next_cfgReadData;
    logic           next_cfgDone;
    logic           next_cfgHit;

    cap_word_if words ();

    cap_word_encoder encoder
    (
        .words (words)
    );

    assign words.upstreamPort = upstreamRole;

    function automatic logic [1:0] decode_word(input logic [ADDR_W-1:0] addr);
        // bit 0 hit first word, bit 1 hit second word; low address bits ignored
        decode_word[0] = addr[ADDR_W-1:2] == OFFSET_CAP_FIRST[ADDR_W-1:2];
        decode_word[1] = addr[ADDR_W-1:2] == OFFSET_CAP_SECOND[ADDR_W-1:2];
    endfunction

    logic [1:0] addrHit;
    assign addrHit = decode_word(cfgAddr);

    // role strap caught one edge after reset release, never under the reset itself
    always_comb
    begin
        next_roleState    = roleState;
        next_upstreamRole = upstreamRole;
        unique case (roleState)
            ROLE_PENDING:
            begin
                next_upstreamRole = upstreamStrap;
                next_roleState    = ROLE_HELD;
            end
            ROLE_HELD:
            begin
                next_roleState = ROLE_HELD;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            roleState    <= ROLE_PENDING;
            upstreamRole <= 1'b0;
        end
        else
        begin
            roleState    <= next_roleState;
            upstreamRole <= next_upstreamRole;
        end
    end

    // access answer: one cycle after the strobe, write data is dropped
    always_comb
    begin
        next_cfgDone     = cfgRead | cfgWrite;
        next_cfgHit      = (cfgRead | cfgWrite) & (|addrHit);
        next_cfgReadData = RESET_WORD;
        if (cfgRead && !cfgWrite)
        begin
            if (addrHit[0])
            begin
                next_cfgReadData = words.firstWord;
            end
            else if (addrHit[1])
            begin
                next_cfgReadData = words.secondWord;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfgReadData <= RESET_WORD;
            cfgDone     <= 1'b0;
            cfgHit      <= 1'b0;
        end
        else
        begin
            cfgReadData <= next_cfgReadData;
            cfgDone     <= next_cfgDone;
            cfgHit      <= next_cfgHit;
        end
    end

    // helper: which word the previous cycle read, for the checks below
    logic readFirst;
    logic readSecond;
    logic next_readFirst;
    logic next_readSecond;

    always_comb
    begin
        next_readFirst  = cfgRead & !cfgWrite & addrHit[0];
        next_readSecond = cfgRead & !cfgWrite & addrHit[1];
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            readFirst  <= 1'b0;
            readSecond <= 1'b0;
        end
        else
        begin
            readFirst  <= next_readFirst;
            readSecond <= next_readSecond;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_extra_count_zero: assert property (readFirst |-> cfgReadData[2:0] == 3'h0)
        else $error("extra channel count not zero");
    a_low_pri_zero: assert property (readFirst |-> cfgReadData[6:4] == 3'h0)
        else $error("low priority channel count not zero");
    a_time_base_zero: assert property (readFirst |-> cfgReadData[9:8] == 2'h0)
        else $error("arbitration time base not zero");
    a_entry_size_role: assert property (readFirst |->
        cfgReadData[11:10] == (upstreamRole ? 2'h2 : 2'h0))
        else $error("entry size does not match port role");
    a_entry_four_bit: assert property ((readFirst && upstreamRole) |->
        cfgReadData[11:10] == ENTRY_FOUR_BIT)
        else $error("upstream entry size not four-bit code");
    a_schemes_zero: assert property (readSecond |-> cfgReadData[7:0] == 8'h00)
        else $error("channel arbitration schemes not zero");
    a_reserved_schemes: assert property (readSecond |->
        cfgReadData[7:4] == 4'h0 && cfgReadData[3:0] == 4'h0)
        else $error("scheme bits set with no low priority group");
    a_table_offset_zero: assert property (readSecond |-> cfgReadData[31:24] == 8'h00)
        else $error("channel table offset not zero");
    a_write_no_effect: assert property ((cfgRead && !cfgWrite && addrHit[0])
        ##1 (cfgWrite && !cfgRead) ##1 (cfgRead && !cfgWrite && addrHit[0])
        |=> cfgReadData == $past(cfgReadData, 2))
        else $error("read value changed after a write");
    a_answer_timing: assert property ((cfgRead || cfgWrite) |=> cfgDone)
        else $error("access not answered in one cycle");
    a_role_steady: assert property ((roleState == ROLE_HELD) |=>
        $stable(upstreamRole))
        else $error("port role changed after capture");

    // reserved bits read as zero in both words
    a_reserved_first: assert property (readFirst |->
        cfgReadData[3] == 1'b0 && cfgReadData[7] == 1'b0 && cfgReadData[31:12] == 20'h00000)
        else $error("reserved bit set in first capability word");
    a_reserved_second: assert property (readSecond |->
        cfgReadData[23:8] == 16'h0000)
        else $error("reserved bit set in second capability word");
    a_entry_downstream: assert property ((readFirst && !upstreamRole) |->
        cfgReadData[11:10] == ENTRY_ONE_BIT)
        else $error("downstream entry size not one-bit code");

    // strap caught on the first edge out of reset
    a_role_capture: assert property ((roleState == ROLE_PENDING) |=>
        upstreamRole == $past(upstreamStrap))
        else $error("port role does not follow the strap");

    // writes, idle cycles and stray addresses answer with zero data
    a_write_no_data: assert property (cfgWrite |=> cfgReadData == 32'h0000_0000)
        else $error("write answered with data");
    a_unmapped_silent: assert property ((cfgDone && !cfgHit) |->
        cfgReadData == 32'h0000_0000)
        else $error("unmapped access answered with data");
    a_idle_silent: assert property (!(cfgRead || cfgWrite) |=>
        !cfgDone && !cfgHit && cfgReadData == 32'h0000_0000)
        else $error("answer without an access");

    c_read_first: cover property (readFirst && cfgHit);
    c_read_second: cover property (readSecond && cfgHit);
    c_write_dropped: cover property (cfgWrite && addrHit[0]);
    c_unmapped: cover property (cfgDone && !cfgHit);
    c_write_between: cover property ((cfgRead && addrHit[0]) ##1 cfgWrite ##1 (cfgRead && addrHit[0]));

endmodule

`default_nettype wire

// file: test/tb.sv
/*
 * Self-checking bench for the port virtual channel capability registers.
 * Assumes the register block answers one cycle after each strobe.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
    import vc_cap_pkg::*;

    logic        clk;
    logic        nrst;
    logic        upstreamStrap;
    logic        cfgRead;
    logic        cfgWrite;
    logic [11:0] cfgAddr;
    logic [31:0] cfgWriteData;
    logic [3:0]  cfgByteEnable;
    logic [31:0] cfgReadData;
    logic        cfgDone;
    logic        cfgHit;
    logic        upstreamRole;
    logic [33:0] pending;
    logic        role;
    logic [31:0] rnd;
    logic [31:0] seed = 32'hc8217b66;
    int          nMismatch;
    int          numChecks;
    logic [11:0] addrTable [8] = '{12'h204, 12'h205, 12'h207, 12'h208,
                                   12'h20b, 12'h200, 12'h20c, 12'h203};

    port_vc_capability_regs dut
    (
        .clk           (clk),
        .nrst          (nrst),
        .upstreamStrap (upstreamStrap),
        .cfgRead       (cfgRead),
        .cfgWrite      (cfgWrite),
        .cfgAddr       (cfgAddr),
        .cfgWriteData  (cfgWriteData),
        .cfgByteEnable (cfgByteEnable),
        .cfgReadData   (cfgReadData),
        .cfgDone       (cfgDone),
        .cfgHit        (cfgHit),
        .upstreamRole  (upstreamRole)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // {done, hit, data}; a read together with a write carries no data
    function automatic logic [33:0] expect_answer(input logic rd, input logic wr,
                                                  input logic [11:0] a, input logic up);
        logic        hit;
        logic [31:0] data;
        hit  = (rd | wr) && (a[11:2] == 10'h081 || a[11:2] == 10'h082);
        data = 32'h0000_0000;
        if (rd && !wr && hit && a[11:2] == 10'h081)
            data[11:10] = up ? 2'h2 : 2'h0;
        return {rd | wr, hit, data};
    endfunction

    task automatic verify(input logic ok, input string msg);
        numChecks++;
        if (ok !== 1'b1)
        begin
            nMismatch++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic report_and_stop();
        if (nMismatch == 0 && numChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // drives one request and checks the answer to the one before it
    task automatic cyc(input logic rd, input logic wr, input logic [11:0] a);
        @(posedge clk);
        cfgRead <= rd;
        cfgWrite <= wr;
        cfgAddr <= a;
        cfgWriteData <= $random(seed);
        cfgByteEnable <= 4'($random(seed));
        #1;
        verify(cfgDone === pending[33] && cfgHit === pending[32],
               "done or hit wrong");
        verify(cfgReadData === pending[31:0],
               "read data wrong");
        pending = expect_answer(rd, wr, a, role);
    endtask

    task automatic do_reset(input logic up);
        @(posedge clk);
        nrst <= 1'b0;
        upstreamStrap <= up;
        cfgRead <= 1'b0;
        cfgWrite <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        verify({cfgDone, cfgHit, cfgReadData, upstreamRole} === 35'h0,
               "outputs not cleared");
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // strap moves after capture: the role must not follow it
        upstreamStrap <= ~up;
        role = up;
        pending = 34'h0;
        #1;
        verify(upstreamRole === up, "port role not captured");
    endtask

    initial
    begin
        nrst = 1'b0;
        upstreamStrap = 1'b0;
        cfgRead = 1'b0;
        cfgWrite = 1'b0;
        cfgAddr = 12'h000;
        cfgWriteData = 32'h0000_0000;
        cfgByteEnable = 4'h0;
        nMismatch = 0;
        numChecks = 0;
        pending = 34'h0;
        role = 1'b0;
        for (int p = 1; p >= 0; p--)
        begin
            do_reset(p[0]);
            // read, write, read back to back: the write must not move the value
            cyc(1'b1, 1'b0, 12'h204);
            cyc(1'b0, 1'b1, 12'h204);
            verify((32'h1 << cfgReadData[11:10]) === (p ? 32'h4 : 32'h1),
                   "entry width wrong");
            cyc(1'b1, 1'b0, 12'h204);
            cyc(1'b0, 1'b0, 12'h000);
            cyc(1'b1, 1'b1, 12'h204);
            cyc(1'b0, 1'b1, 12'h208);
            cyc(1'b1, 1'b0, 12'h208);
            cyc(1'b1, 1'b0, 12'h20c);
            foreach (addrTable[i])
                cyc(1'b1, 1'b0, addrTable[i]);
            // back-to-back mix of reads, writes and stray addresses
            repeat (300)
            begin
                rnd = $random(seed);
                cyc(rnd[0], rnd[1] & rnd[2],
                    rnd[3] ? addrTable[rnd[6:4]] : rnd[27:16]);
            end
            cyc(1'b0, 1'b0, 12'h000);
            cyc(1'b0, 1'b0, 12'h000);
        end
        report_and_stop();
    end

    // the full run needs under 800 cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        nMismatch++;
        report_and_stop();
    end
endmodule

`default_nettype wire
